/* logic/drive_supervision.sv */
// drive supervision: frequency detection, command loss, fault restart, torque detection
// assumes all measurement and fault inputs come from logic on ref_clk_i,
// one ahb-lite master, and a later stage that honours drive_en_o and freq_ref_o
`timescale 1ns/100ps
module drive_supervision
  import drive_sup_pkg::*;
#(
  parameter int unsigned MS_CYCLES = TICK_MS_CYCLES
) (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  input  wire logic        run_cmd_i,
  input  wire logic [15:0] out_freq_i,
  input  wire logic [15:0] freq_cmd_i,
  input  wire logic [15:0] max_output_freq_i,
  input  wire logic [15:0] motor2_max_output_freq_i,
  input  wire logic        motor2_active_i,
  input  wire logic [15:0] freq_cmd_upper_limit_i,
  input  wire logic [11:0] analog_in_first_i,
  input  wire logic [11:0] analog_in_second_i,
  input  wire logic        cmd_from_second_i,
  input  wire logic [12:0] restart_fault_i,
  input  wire logic        other_fault_i,
  input  wire logic        selftest_ok_i,
  input  wire logic        vector_method_i,
  input  wire logic [8:0]  current_pct_i,
  input  wire logic [8:0]  torque_pct_i,
  input  wire logic        torque_level_analog_en_i,
  input  wire logic [8:0]  torque_level_analog_i,
  input  wire logic        torque_ch2_i,
  output logic [3:0]       term_o,
  output logic [15:0]      freq_ref_o,
  output logic             drive_en_o,
  output logic             run_o,
  output logic             speed_search_o,
  output logic             lockout_o
);

  typedef struct packed {
    logic           wr_pend;
    logic [7:0]     wr_addr;
    logic [31:0]    rdata;
    logic [31:0]    freq_cfg;
    logic [31:0]    loss_cfg;
    logic [31:0]    rst_cfg;
    logic [31:0]    trq_cfg;
    logic [31:0]    out_fn;
    logic [17:0]    ms_cnt;
    logic [6:0]     tenth_cnt;
    logic [11:0]    cmd_ref;
    logic [8:0]     win_cnt;
    logic           loss;
    restart_state_e rs;
    logic [3:0]     attempts;
    logic [12:0]    ivl_cnt;
    logic [12:0]    ok_cnt;
    logic           after_restart;
    logic           search;
    logic [13:0]    trq_cnt;
    logic           trq_det;
    logic [3:0]     term;
    logic [15:0]    freq_ref;
    logic           drive_en;
    logic           run;
  } state_s;

  state_s r_reg;
  state_s r_next;

  // decoded configuration fields
  logic [15:0] det_level;
  logic [15:0] det_width;
  logic        loss_sel;
  logic [9:0]  fall_pct;
  logic [8:0]  loss_time;
  logic [3:0]  rst_limit;
  logic        fault_out_en;
  logic [12:0] rst_ivl;
  logic [3:0]  trq_sel;
  logic [8:0]  trq_level;
  logic [7:0]  trq_time;

  assign det_level    = r_reg.freq_cfg[FREQ_LEVEL_LSB +: 16];
  assign det_width    = {8'h00, r_reg.freq_cfg[FREQ_WIDTH_LSB +: 8]};
  assign loss_sel     = r_reg.loss_cfg[LOSS_SEL_LSB];
  assign fall_pct     = r_reg.loss_cfg[LOSS_FALL_LSB +: 10];
  assign rst_limit    = r_reg.rst_cfg[RST_LIMIT_LSB +: 4];
  assign fault_out_en = r_reg.rst_cfg[RST_FOUT_LSB];
  assign trq_sel      = r_reg.trq_cfg[TRQ_SEL_LSB +: 4];
  assign trq_time     = r_reg.trq_cfg[TRQ_TIME_LSB +: 8];

  // out-of-range settings are clamped here rather than refused at write
  assign loss_time = (r_reg.loss_cfg[LOSS_TIME_LSB +: 9] < LOSS_TIME_MIN) ? LOSS_TIME_MIN :
                     (r_reg.loss_cfg[LOSS_TIME_LSB +: 9] > LOSS_TIME_MAX) ? LOSS_TIME_MAX :
                     r_reg.loss_cfg[LOSS_TIME_LSB +: 9];
  assign rst_ivl   = (r_reg.rst_cfg[RST_IVL_LSB +: 13] < RST_IVL_MIN) ? RST_IVL_MIN :
                     r_reg.rst_cfg[RST_IVL_LSB +: 13];
  // analog override of the channel 1 level
  assign trq_level = torque_level_analog_en_i ? torque_level_analog_i :
                     r_reg.trq_cfg[TRQ_LEVEL_LSB +: 9];

  // derived combinational terms
  logic        ms_tick;
  logic        tenth_tick;
  logic [15:0] act_max;
  logic [15:0] lvl_limit;
  logic [15:0] lvl_eff;
  logic [15:0] band_diff;
  logic        in_band;
  logic [11:0] analog_cmd;
  logic        below_90;
  logic [15:0] fallback;
  logic [8:0]  trq_meas;
  logic        trq_over;
  logic        trq_agree_mode;
  logic        trq_fault_mode;
  logic        trq_enabled;
  logic        trq_past;
  logic        trq_released;
  logic        trq_fault;
  logic        restartable;
  logic        fault_reset;
  logic        restart_active;
  logic        addr_ok;

  assign ms_tick    = (r_reg.ms_cnt == 18'(MS_CYCLES - 1));
  assign tenth_tick = ms_tick && (r_reg.tenth_cnt == 7'(TENTH_MS - 1));

  // level clamp against the active maximum and the command upper limit
  assign act_max   = motor2_active_i ? motor2_max_output_freq_i : max_output_freq_i;
  assign lvl_limit = (act_max < freq_cmd_upper_limit_i) ? act_max : freq_cmd_upper_limit_i;
  assign lvl_eff   = (det_level > lvl_limit) ? lvl_limit : det_level;
  assign band_diff = (out_freq_i >= lvl_eff) ? out_freq_i - lvl_eff : lvl_eff - out_freq_i;
  assign in_band   = (band_diff <= det_width);

  // command loss compares against the value held at the last window edge
  assign analog_cmd = cmd_from_second_i ? analog_in_second_i : analog_in_first_i;
  assign below_90   = ({4'h0, analog_cmd} * LOSS_DEN) < ({4'h0, r_reg.cmd_ref} * LOSS_NUM);
  assign fallback   = 16'(({10'h000, act_max} * {16'h0000, fall_pct}) / PERMILLE);

  // torque channel 1 decode: 1-4 over, 5-8 under; odd at agree; 3,4,7,8 fault
  assign trq_meas       = vector_method_i ? torque_pct_i : current_pct_i;
  assign trq_over       = (trq_sel <= 4'd4);
  assign trq_agree_mode = trq_sel[0];
  assign trq_fault_mode = (trq_sel == 4'd3) || (trq_sel == 4'd4) ||
                          (trq_sel == 4'd7) || (trq_sel == 4'd8);
  assign trq_enabled    = (trq_sel != 4'd0) && (trq_sel <= TRQ_SEL_MAX) && run_cmd_i &&
                          (r_reg.rs == RS_RUN) && (!trq_agree_mode || out_freq_i == freq_cmd_i);
  assign trq_past       = trq_over ? (trq_meas > trq_level) : (trq_meas < trq_level);
  assign trq_released   = trq_over ? ({1'b0, trq_meas} + TRQ_HYST_PCT < {1'b0, trq_level}) :
                          ({1'b0, trq_meas} > {1'b0, trq_level} + TRQ_HYST_PCT);
  assign trq_fault      = r_reg.trq_det && trq_fault_mode;

  assign restartable    = (|restart_fault_i) || trq_fault;
  assign restart_active = (r_reg.rs == RS_WAIT) || (r_reg.rs == RS_DIAG);
  assign fault_reset    = r_reg.wr_pend && (r_reg.wr_addr == CTRL_OFS) && hwdata_i[CTRL_FRESET_LSB];
  assign addr_ok        = hsel_i && htrans_i[1] && hready_i;

  // whole next-state computation in one place
  always_comb begin
    r_next        = r_reg;
    r_next.search = 1'b0;

    // ahb data phase: write the register latched in the address phase
    r_next.wr_pend = addr_ok && hwrite_i;
    r_next.wr_addr = haddr_i[7:0];
    if (r_reg.wr_pend) begin
      case (r_reg.wr_addr)
        FREQ_CFG_OFS: r_next.freq_cfg = hwdata_i;
        LOSS_CFG_OFS: r_next.loss_cfg = hwdata_i;
        RST_CFG_OFS:  r_next.rst_cfg  = hwdata_i;
        TRQ_CFG_OFS:  r_next.trq_cfg  = hwdata_i;
        OUT_FN_OFS:   r_next.out_fn   = hwdata_i;
        default:      r_next.rdata    = r_reg.rdata;   // ctrl and unmapped hold nothing
      endcase
    end
    // read data captured in the address phase; unmapped reads give zero
    if (addr_ok && !hwrite_i) begin
      case (haddr_i[7:0])
        FREQ_CFG_OFS: r_next.rdata = r_reg.freq_cfg;
        LOSS_CFG_OFS: r_next.rdata = r_reg.loss_cfg;
        RST_CFG_OFS:  r_next.rdata = r_reg.rst_cfg;
        TRQ_CFG_OFS:  r_next.rdata = r_reg.trq_cfg;
        OUT_FN_OFS:   r_next.rdata = r_reg.out_fn;
        STATUS_OFS:   r_next.rdata = {16'h0000, r_reg.attempts, 2'(r_reg.rs), r_reg.trq_det,
                                      r_reg.loss, 4'h0, r_reg.after_restart, restart_active,
                                      r_reg.run, r_reg.drive_en};
        default:      r_next.rdata = 32'h00000000;
      endcase
    end

    // millisecond and tenth-second enables
    r_next.ms_cnt = ms_tick ? 18'h00000 : r_reg.ms_cnt + 18'h00001;
    if (ms_tick) begin
      r_next.tenth_cnt = tenth_tick ? 7'h00 : r_reg.tenth_cnt + 7'h01;
    end

    // command loss: reference refreshed each window while the command is healthy
    if (!r_reg.loss) begin
      if (below_90) begin
        r_next.loss    = 1'b1;
        r_next.win_cnt = 9'h000;
      end else if (ms_tick) begin
        if (r_reg.win_cnt >= loss_time - 9'h001) begin
          r_next.win_cnt = 9'h000;
          r_next.cmd_ref = analog_cmd;
        end else begin
          r_next.win_cnt = r_reg.win_cnt + 9'h001;
        end
      end
    end else if (!below_90) begin
      r_next.loss    = 1'b0;
      r_next.cmd_ref = analog_cmd;
    end

    // torque channel 1: timer held in the dead band, cleared on release
    if (!trq_enabled) begin
      r_next.trq_cnt = 14'h0000;
      r_next.trq_det = 1'b0;
    end else if (trq_released) begin
      r_next.trq_cnt = 14'h0000;
      r_next.trq_det = 1'b0;
    end else if (trq_past && !r_reg.trq_det) begin
      if (r_reg.trq_cnt >= 14'(trq_time) * 14'(TENTH_MS)) begin
        r_next.trq_det = 1'b1;
      end else if (ms_tick) begin
        r_next.trq_cnt = r_reg.trq_cnt + 14'h0001;
      end
    end

    // fault restart sequencer
    case (r_reg.rs)
      RS_RUN: begin
        if (r_reg.after_restart && r_reg.run && tenth_tick) begin
          if (r_reg.ok_cnt >= OK_RUN_TENTHS - 13'h0001) begin
            r_next.attempts      = 4'h0;
            r_next.after_restart = 1'b0;
          end else begin
            r_next.ok_cnt = r_reg.ok_cnt + 13'h0001;
          end
        end
        if (other_fault_i || (restartable && !run_cmd_i)) begin
          r_next.rs = RS_LOCK;
        end else if (restartable) begin
          if (r_reg.attempts >= rst_limit || r_reg.attempts >= RST_LIMIT_MAX) begin
            r_next.rs = RS_LOCK;
          end else begin
            r_next.rs      = RS_WAIT;
            r_next.ivl_cnt = 13'h0000;
          end
        end
      end
      RS_WAIT: begin
        if (tenth_tick) begin
          if (r_reg.ivl_cnt >= rst_ivl - 13'h0001) begin
            r_next.rs = RS_DIAG;
          end else begin
            r_next.ivl_cnt = r_reg.ivl_cnt + 13'h0001;
          end
        end
      end
      RS_DIAG: begin
        // self-diagnosis passes only with every fault source gone
        if (selftest_ok_i && !(|restart_fault_i) && !other_fault_i) begin
          r_next.rs            = RS_RUN;
          r_next.attempts      = r_reg.attempts + 4'h1;
          r_next.search        = 1'b1;
          r_next.after_restart = 1'b1;
          r_next.ok_cnt        = 13'h0000;
        end else begin
          r_next.rs = RS_LOCK;
        end
      end
      RS_LOCK: r_next.rs = RS_LOCK;
      default: r_next.rs = RS_LOCK;
    endcase
    // manual reset releases the lock and clears the attempt count
    if (fault_reset) begin
      r_next.rs            = RS_RUN;
      r_next.attempts      = 4'h0;
      r_next.after_restart = 1'b0;
      r_next.ok_cnt        = 13'h0000;
    end

    // drive command outputs
    r_next.drive_en = (r_next.rs == RS_RUN) && !(r_reg.loss && !loss_sel) && !trq_fault;
    r_next.run      = r_next.drive_en && run_cmd_i;
    r_next.freq_ref = (r_reg.loss && loss_sel) ? fallback : freq_cmd_i;

    // multi-function terminals, each picking its function code
    for (int i = 0; i < NUM_TERMS; i++) begin
      case (r_reg.out_fn[i*OUT_FN_STRIDE +: 5])
        FN_FREQ_AGREE, FN_USER_AGREE,
        FN_FREQ_DET1, FN_FREQ_DET2: r_next.term[i] = in_band;
        FN_CMD_LOSS:  r_next.term[i] = r_reg.loss;
        FN_FAULT:     r_next.term[i] = (r_reg.rs == RS_LOCK) ||
                                       (restart_active && fault_out_en);
        FN_RESTART:   r_next.term[i] = restart_active;
        FN_TORQUE1:   r_next.term[i] = r_reg.trq_det;
        FN_TORQUE2:   r_next.term[i] = torque_ch2_i;
        default:      r_next.term[i] = 1'b0;
      endcase
    end
  end

  // single state register; reset doubles as power-up clear of the counter
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      r_reg          <= '0;
      r_reg.freq_cfg <= FREQ_CFG_RST;
      r_reg.loss_cfg <= LOSS_CFG_RST;
      r_reg.rst_cfg  <= RST_CFG_RST;
      r_reg.trq_cfg  <= TRQ_CFG_RST;
      r_reg.out_fn   <= OUT_FN_RST;
      r_reg.rs       <= RS_RUN;
    end else begin
      r_reg <= r_next;
    end
  end

  assign hreadyout_o    = 1'b1;   // zero wait states
  assign hresp_o        = 1'b0;   // always okay
  assign hrdata_o       = r_reg.rdata;
  assign term_o         = r_reg.term;
  assign freq_ref_o     = r_reg.freq_ref;
  assign drive_en_o     = r_reg.drive_en;
  assign run_o          = r_reg.run;
  assign speed_search_o = r_reg.search;
  assign lockout_o      = (r_reg.rs == RS_LOCK);

  // checks on the supervision behaviour
  sequence s_restart_fault;
    r_reg.rs == RS_RUN && !other_fault_i && restartable && run_cmd_i &&
    r_reg.attempts < rst_limit && r_reg.attempts < RST_LIMIT_MAX && !fault_reset;
  endsequence

  a_restart_stops: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    s_restart_fault |=> !drive_en_o && !run_o && r_reg.rs == RS_WAIT)
    else $error("restartable fault did not stop the output");
  a_limit_locks: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    r_reg.rs == RS_RUN && restartable && run_cmd_i && r_reg.attempts >= rst_limit &&
    !fault_reset |=> lockout_o)
    else $error("attempt limit did not lock out");
  a_lock_holds: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    lockout_o && !fault_reset |=> lockout_o && !drive_en_o)
    else $error("lockout released without manual reset");
  a_reset_clears: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    fault_reset |=> r_reg.attempts == 4'h0 && !lockout_o)
    else $error("manual reset did not clear attempts");
  a_loss_term: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    r_reg.out_fn[12:8] == FN_CMD_LOSS && $stable(r_reg.out_fn) |=> term_o[1] == $past(r_reg.loss))
    else $error("code 9 output does not follow command loss");
  a_fallback_freq: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    r_reg.loss && loss_sel |=> freq_ref_o == $past(fallback))
    else $error("fallback frequency not applied during loss");
  a_loss_stops: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    r_reg.loss && !loss_sel |=> !drive_en_o)
    else $error("loss with select 0 did not stop the drive");
  a_fault_gate: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    restart_active && !fault_out_en && r_reg.out_fn[28:24] == FN_FAULT ##1
    restart_active && !fault_out_en |-> !term_o[3])
    else $error("fault output shown during restart while disabled");
  a_torque_off: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    trq_sel == 4'd0 ##1 trq_sel == 4'd0 |-> !r_reg.trq_det)
    else $error("torque detection active with selection 0");
  a_search_pulse: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    speed_search_o |-> ##1 !speed_search_o)
    else $error("speed search pulse longer than one cycle");

endmodule

/* inc/drive_sup_pkg.sv */
// constants, register map and state types of the drive supervision block
// assumes a 250 mhz system clock and a single ahb-lite master
package drive_sup_pkg;

  // register byte offsets
  localparam logic [7:0] FREQ_CFG_OFS   = 8'h00;
  localparam logic [7:0] LOSS_CFG_OFS   = 8'h04;
  localparam logic [7:0] RST_CFG_OFS    = 8'h08;
  localparam logic [7:0] TRQ_CFG_OFS    = 8'h0c;
  localparam logic [7:0] OUT_FN_OFS     = 8'h10;
  localparam logic [7:0] CTRL_OFS       = 8'h14;
  localparam logic [7:0] STATUS_OFS     = 8'h18;

  // field positions
  localparam int FREQ_LEVEL_LSB  = 0;   // 16 bits, 0.1 hz
  localparam int FREQ_WIDTH_LSB  = 16;  // 8 bits, 0.1 hz
  localparam int LOSS_SEL_LSB    = 0;   // 1 bit
  localparam int LOSS_FALL_LSB   = 4;   // 10 bits, 0.1 %
  localparam int LOSS_TIME_LSB   = 16;  // 9 bits, ms
  localparam int RST_LIMIT_LSB   = 0;   // 4 bits
  localparam int RST_FOUT_LSB    = 4;   // 1 bit
  localparam int RST_IVL_LSB     = 16;  // 13 bits, 0.1 s
  localparam int TRQ_SEL_LSB     = 0;   // 4 bits
  localparam int TRQ_LEVEL_LSB   = 4;   // 9 bits, %
  localparam int TRQ_TIME_LSB    = 16;  // 8 bits, 0.1 s
  localparam int OUT_FN_STRIDE   = 8;   // 5-bit code per terminal
  localparam int CTRL_FRESET_LSB = 0;

  // reset values: level 30.0 hz, width 2.0 hz, fallback 80.0 %, 20 ms,
  // limit 0, fault output off, interval 10.0 s, torque off, 150 %, 0.1 s
  localparam logic [31:0] FREQ_CFG_RST = 32'h0014012c;
  localparam logic [31:0] LOSS_CFG_RST = 32'h00143200;
  localparam logic [31:0] RST_CFG_RST  = 32'h00640000;
  localparam logic [31:0] TRQ_CFG_RST  = 32'h00010960;
  localparam logic [31:0] OUT_FN_RST   = 32'h00000000;

  // multi-function output codes
  localparam logic [4:0] FN_FREQ_AGREE   = 5'h02;
  localparam logic [4:0] FN_USER_AGREE   = 5'h03;
  localparam logic [4:0] FN_CMD_LOSS     = 5'h09;
  localparam logic [4:0] FN_FAULT        = 5'h0b;
  localparam logic [4:0] FN_RESTART      = 5'h0e;
  localparam logic [4:0] FN_FREQ_DET1    = 5'h10;
  localparam logic [4:0] FN_FREQ_DET2    = 5'h11;
  localparam logic [4:0] FN_TORQUE1      = 5'h12;
  localparam logic [4:0] FN_TORQUE2      = 5'h14;

  // limits and timing
  localparam int unsigned CLK_HZ         = 250_000_000;
  localparam int unsigned MS_PER_S       = 1000;
  localparam int unsigned TICK_MS_CYCLES = CLK_HZ / MS_PER_S;
  localparam int unsigned TENTH_MS       = 100;     // ms per 0.1 s step
  localparam int unsigned OK_RUN_MIN     = 10;      // minutes of clean running
  localparam logic [12:0] OK_RUN_TENTHS  = 13'(OK_RUN_MIN * 60 * 10);
  localparam logic [8:0]  LOSS_TIME_MIN  = 9'd20;
  localparam logic [8:0]  LOSS_TIME_MAX  = 9'd400;
  localparam logic [3:0]  RST_LIMIT_MAX  = 4'd10;
  localparam logic [12:0] RST_IVL_MIN    = 13'd5;
  localparam logic [3:0]  TRQ_SEL_MAX    = 4'd8;
  localparam logic [9:0]  TRQ_HYST_PCT   = 10'd10;
  localparam logic [15:0] LOSS_NUM       = 16'd9;    // 90 % as 9 / 10
  localparam logic [15:0] LOSS_DEN       = 16'd10;
  localparam logic [25:0] PERMILLE       = 26'd1000;
  localparam int          NUM_TERMS      = 4;

  typedef enum logic [1:0] {RS_RUN, RS_WAIT, RS_DIAG, RS_LOCK} restart_state_e;

endpackage

/* test/motor_model.sv */
// motor model: speed follows the reference while run is given
// assumes registered drive outputs on the same clock
`timescale 1ns/100ps
module motor_model (
  input  wire logic        clk_i,
  input  wire logic        run_i,
  input  wire logic [15:0] ref_i,
  output logic      [15:0] speed_o = 16'h0000
);
  // coasts to zero at once, so a stale speed never fakes agreement
  always @(posedge clk_i) begin
    speed_o <= run_i ? ref_i : 16'h0000;
  end
endmodule

/* test/drive_supervision_tb_top.sv */
// bench for drive supervision: bus reads, band, command loss, restart
// assumes a zero-wait slave and a shortened millisecond tick
`timescale 1ns/100ps
module drive_supervision_tb_top import drive_sup_pkg::*;;
  logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwr = 1'b0, run = 1'b0, want = 1'b0;
  logic [1:0]  htrans = 2'h0;
  logic [7:0]  haddr = 8'h00;
  logic [31:0] hwdata = 32'h0, hrdata;
  logic [15:0] fcmd = 16'h012c, fref, ofreq;
  logic [11:0] ain = 12'h3e8;
  logic [12:0] rfault = 13'h0;
  logic [3:0]  term;
  logic        hrdy, ss, en, rn, lock, hresp;
  logic        m2sel = 1'b0, csel = 1'b0, ofault = 1'b0, stok = 1'b1, vec = 1'b0;
  logic        tlen = 1'b0, ch2 = 1'b0;
  logic [15:0] mx = 16'h0258, mx2 = 16'h0258, ulim = 16'h0258;
  logic [11:0] ain2 = 12'h000;
  logic [8:0]  cur = 9'h000, tpct = 9'h000, tlvl = 9'h000;
  logic [64:0] exp_q[$];
  int          n_mismatch = 0, compares = 0, seed = 29;
  wire  [31:0] obs = {8'h00, fref, term, en, rn, lock, hresp};   // response must stay okay

  initial forever #2 clk = ~clk;
  motor_model motor_model_inst (.clk_i(clk), .run_i(rn), .ref_i(fref), .speed_o(ofreq));
  drive_supervision #(.MS_CYCLES(4)) drive_supervision_inst (
    .ref_clk_i(clk), .rst_n_i(rst_n), .hsel_i(hsel), .haddr_i({24'h0, haddr}),
    .htrans_i(htrans), .hwrite_i(hwr), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy),
    .hreadyout_o(hrdy), .hresp_o(hresp), .hrdata_o(hrdata), .run_cmd_i(run), .out_freq_i(ofreq),
    .freq_cmd_i(fcmd), .max_output_freq_i(mx), .motor2_max_output_freq_i(mx2),
    .motor2_active_i(m2sel), .freq_cmd_upper_limit_i(ulim), .analog_in_first_i(ain),
    .analog_in_second_i(ain2), .cmd_from_second_i(csel), .restart_fault_i(rfault),
    .other_fault_i(ofault), .selftest_ok_i(stok), .vector_method_i(vec), .current_pct_i(cur),
    .torque_pct_i(tpct), .torque_level_analog_en_i(tlen), .torque_level_analog_i(tlvl),
    .torque_ch2_i(ch2), .term_o(term), .freq_ref_o(fref), .drive_en_o(en), .run_o(rn),
    .speed_search_o(ss), .lockout_o(lock));

  // single word transfer; for a read, d is the expected word
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1; htrans <= 2'h2; hwr <= wr; haddr <= a;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= d;
    if (!wr) begin exp_q.push_back({1'b0, 32'hffffffff, d}); want <= 1'b1; end
    do @(posedge clk); while (hrdy !== 1'b1);
    want <= 1'b0;
  endtask
  // note an expected port vector, sampled at the next edge
  task automatic chk(input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({1'b1, m, e}); want <= 1'b1;
    @(posedge clk);
    want <= 1'b0;
  endtask
  task automatic finish_test();
    if (n_mismatch == 0 && compares > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // oldest note is matched against read data or the port vector
  always @(posedge clk) begin
    if (want && exp_q.size() > 0) begin
      compares++;
      if (((exp_q[0][64] ? obs : hrdata) & exp_q[0][63:32]) !== exp_q[0][31:0]) begin
        n_mismatch++;
        $display("ERROR %0t: got %h expected %h", $time, exp_q[0][64] ? obs : hrdata, exp_q[0][31:0]);
      end
      void'(exp_q.pop_front());
    end
  end
  // the scenarios need about 2850 cycles; allow three and a half times that
  initial begin
    #40000;
    n_mismatch++;
    $display("ERROR %0t: timeout", $time);
    finish_test();
  end

  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    bus(0, FREQ_CFG_OFS, FREQ_CFG_RST);
    bus(0, LOSS_CFG_OFS, LOSS_CFG_RST);
    bus(0, RST_CFG_OFS, RST_CFG_RST);
    bus(0, TRQ_CFG_OFS, TRQ_CFG_RST);
    bus(0, 8'h3c, 32'h0);
    bus(1, OUT_FN_OFS, {3'h0, FN_FAULT, 3'h0, FN_RESTART, 3'h0, FN_CMD_LOSS, 3'h0, FN_FREQ_AGREE});
    run <= 1'b1;
    // random commands inside the band, then one outside, then a clamped level
    for (int i = 0; i < 5; i++) begin
      fcmd <= (i == 4) ? 16'd330 : 16'(280 + {$random(seed)} % 41);
      repeat (8) @(posedge clk);
      chk({8'h00, fcmd, (i == 4) ? 8'h0c : 8'h1c}, 32'hffffffff);
    end
    bus(1, FREQ_CFG_OFS, 32'h001403e8);
    fcmd <= 16'h0258;
    repeat (8) @(posedge clk);
    chk(32'h0002581c, 32'hffffffff);
    bus(1, FREQ_CFG_OFS, FREQ_CFG_RST);
    fcmd <= 16'h012c;
    // command loss: stop first, then fallback of 80.0 % of the second motor's 50.0 hz
    for (int s = 0; s < 2; s++) begin
      if (s == 1) begin
        bus(1, LOSS_CFG_OFS, 32'h00143201);
        mx2   <= 16'h01f4;
        m2sel <= 1'b1;
      end
      repeat (200) @(posedge clk);
      ain <= 12'h320;
      repeat (6) @(posedge clk);
      chk(s ? 32'h0001902c : 32'h00000020, s ? 32'hffffffff : 32'hff);
      ain <= 12'h3e8;
    end
    // overtorque alarm at run: detect after 0.1 s, hold in the hysteresis band, release below
    bus(1, TRQ_CFG_OFS, 32'h00010962);
    cur <= 9'd160;
    repeat (450) @(posedge clk);
    bus(0, STATUS_OFS, 32'h00000203);
    cur <= 9'd145;
    repeat (4) @(posedge clk);
    bus(0, STATUS_OFS, 32'h00000203);
    cur <= 9'd130;
    repeat (4) @(posedge clk);
    bus(0, STATUS_OFS, 32'h00000003);
    bus(1, TRQ_CFG_OFS, TRQ_CFG_RST);
    bus(1, RST_CFG_OFS, 32'h00050011);
    // restart: wait state shown, still waiting short of the 0.5 s interval, then search
    rfault <= 13'h0001;
    repeat (3) @(posedge clk);
    rfault <= 13'h0000;
    repeat (3) @(posedge clk);
    chk(32'h000000c0, 32'hff);
    repeat (1580) @(posedge clk);
    chk(32'h000000c0, 32'hff);
    for (int i = 0; i < 600 && ss !== 1'b1; i++) @(posedge clk);
    if (ss !== 1'b1) begin
      n_mismatch++;
      $display("ERROR %0t: no automatic restart", $time);
    end
    repeat (8) @(posedge clk);
    chk(32'h00012c1c, 32'hffffffff);
    // a fault at the attempt limit, then a fault that may not restart: both lock out
    for (int k = 0; k < 2; k++) begin
      rfault <= (k == 0) ? 13'h0100 : 13'h0000;
      ofault <= (k == 1);
      repeat (3) @(posedge clk);
      rfault <= 13'h0000;
      ofault <= 1'b0;
      repeat (3) @(posedge clk);
      chk(32'h00000082, 32'hff);
      bus(1, CTRL_OFS, 32'h1);
      bus(0, STATUS_OFS, 32'h00000003);
    end
    // fault output withheld during restart while not enabled
    bus(1, RST_CFG_OFS, 32'h00050002);
    rfault <= 13'h1000;
    repeat (3) @(posedge clk);
    rfault <= 13'h0000;
    repeat (3) @(posedge clk);
    chk(32'h00000040, 32'hff);
    // let the checker take the last note before the run ends
    @(posedge clk);
    finish_test();
  end
endmodule
